// >>> logic/floppy_track_command_engine.sv
// Execution phase of the write, deleted, track, read-ID and format commands.
// Assumes a byte-level codec on REF_CLK delivers decoded ID fields, marks and
// data bytes, and accepts a marked byte stream for writing; drive pins are async.
`timescale 1ns/1ps
module floppy_track_command_engine
	import fdc_track_pkg::*;
#(
	parameter int WR_SERVICE_FM_LIMIT = WR_SERVICE_FM_CYC,
	parameter int WR_SERVICE_MFM_LIMIT = WR_SERVICE_MFM_CYC
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// Command phase
	input wire logic CMD_START,
	input wire cmd_params_t CMD_PARAMS,
	input wire logic [15:0] SETTLE_CYCLES,
	output logic BUSY,
	output logic DONE,
	output result_t RESULT,
	// Host data
	output logic HOST_DREQ,
	input wire logic HOST_WR_VALID,
	input wire logic [7:0] HOST_WR_DATA,
	output logic HOST_RD_VALID,
	output logic [7:0] HOST_RD_DATA,
	input wire logic TERMINAL_COUNT,
	// Drive pins
	input wire logic DRIVE_INDEX,
	input wire logic DRIVE_FAULT,
	input wire logic DRIVE_READY,
	output logic HEAD_LOAD,
	// Codec read side
	input wire logic DISK_ID_VALID,
	input wire chrn_t DISK_ID,
	input wire logic DISK_ID_CRC_OK,
	input wire logic DISK_MARK_VALID,
	input wire logic DISK_MARK_DELETED,
	input wire logic DISK_RD_VALID,
	input wire logic [7:0] DISK_RD_DATA,
	// Codec write side
	output disk_byte_t DISK_WR,
	input wire logic DISK_WR_READY
);
	typedef struct packed {
		state_t state;
		cmd_params_t p;
		fmt_phase_t fph;
		chrn_t cur;
		chrn_t fmt_id;
		logic [1:0] idx_cnt;
		logic idx_prev;
		logic id_found;
		logic cm_pending;
		logic tc_seen;
		logic [13:0] byte_cnt;
		logic [7:0] sec_cnt;
		logic [7:0] hold;
		logic hold_full;
		logic [12:0] svc_cnt;
		logic [15:0] settle_cnt;
		disk_byte_t wr;
		logic rd_valid;
		logic [7:0] rd_data;
		logic [7:0] st0;
		logic [7:0] st1;
		logic [7:0] st2;
		logic done;
	} eng_state_t;

	eng_state_t s;
	eng_state_t next_s;
	logic [2:0] pins;
	logic index_lvl;
	logic fault_lvl;
	logic ready_lvl;
	logic index_edge;
	logic slot_free;
	logic [13:0] sector_last;
	logic [12:0] svc_limit;
	logic is_write;
	logic dreq;

	level_sync #(.WIDTH(3)) u_pin_sync (
		.clk(REF_CLK),
		.resetn(RESETN),
		.d({DRIVE_INDEX, DRIVE_FAULT, DRIVE_READY}),
		.q(pins)
	);

	assign index_lvl = pins[2];
	assign fault_lvl = pins[1];
	assign ready_lvl = pins[0];
	assign index_edge = index_lvl && !s.idx_prev;
	assign slot_free = !s.wr.valid || DISK_WR_READY;
	// Index of the last byte of one data field (byte count minus one)
	assign sector_last = 14'((SECTOR_BASE_BYTES << s.p.size_code) - 1);
	assign svc_limit = s.p.mfm ? 13'(WR_SERVICE_MFM_LIMIT) : 13'(WR_SERVICE_FM_LIMIT);
	assign is_write = (s.p.code == CMD_WRITE) || (s.p.code == CMD_WRITE_DELETED);
	// Host must answer every request in turn; the holding byte is the only buffer
	assign dreq = (s.state == ST_WRITE_DATA && is_write && !s.hold_full && !s.tc_seen)
		|| (s.state == ST_FORMAT && s.fph == FMT_REQUEST && !s.hold_full);

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.rd_valid = 1'b0;
		next_s.idx_prev = index_lvl;
		if (s.wr.valid && DISK_WR_READY) begin
			next_s.wr.valid = 1'b0;
		end
		if (s.state != ST_IDLE && TERMINAL_COUNT) begin
			next_s.tc_seen = 1'b1;
		end
		if (s.state != ST_IDLE && index_edge && s.idx_cnt != INDEX_LIMIT) begin
			next_s.idx_cnt = s.idx_cnt + 2'h1;
		end
		case (s.state)
			ST_IDLE: begin
				if (CMD_START) begin
					next_s.p = CMD_PARAMS;
					next_s.cur = CMD_PARAMS.id_compare_register;
					next_s.st0 = STATUS_RESET;
					next_s.st1 = STATUS_RESET;
					next_s.st2 = STATUS_RESET;
					next_s.idx_cnt = 2'h0;
					next_s.id_found = 1'b0;
					next_s.cm_pending = 1'b0;
					next_s.tc_seen = 1'b0;
					next_s.hold_full = 1'b0;
					next_s.sec_cnt = 8'h00;
					next_s.byte_cnt = 14'h0000;
					next_s.svc_cnt = 13'h0000;
					next_s.settle_cnt = SETTLE_CYCLES;
					next_s.fph = FMT_REQUEST;
					if (CMD_PARAMS.size_code > SIZE_CODE_MAX) begin
						next_s.p.size_code = SIZE_CODE_MAX;
					end
					if (!ready_lvl) begin
						next_s.st0[ST0_NOT_READY_BIT] = 1'b1;
						next_s.st0[ST0_IC_HI:ST0_IC_LO] = 2'b01;
						next_s.done = 1'b1;
					end else begin
						next_s.state = ST_SETTLE;
					end
				end
			end
			ST_SETTLE: begin
				// Head is loaded here; settle before looking at the track
				if (s.settle_cnt != SETTLE_RESET) begin
					next_s.settle_cnt = s.settle_cnt - 16'h0001;
				end else if (s.p.code == CMD_READ_TRACK || s.p.code == CMD_FORMAT) begin
					next_s.state = ST_WAIT_INDEX;
				end else begin
					next_s.idx_cnt = 2'h0;
					next_s.state = ST_SEEK_ID;
				end
			end
			ST_WAIT_INDEX: begin
				// The first index pulse opens the track
				next_s.idx_cnt = 2'h1;
				if (index_edge) begin
					next_s.state = (s.p.code == CMD_FORMAT) ? ST_FORMAT : ST_SEEK_ID;
				end
			end
			ST_SEEK_ID: begin
				if (s.idx_cnt == INDEX_LIMIT) begin
					next_s.st0[ST0_IC_HI:ST0_IC_LO] = 2'b01;
					if (s.p.code == CMD_READ_TRACK) begin
						next_s.st1[ST1_ABSENT_ID_BIT] = !s.id_found;
					end else if (s.p.code == CMD_READ_ID) begin
						next_s.st1[ST1_ABSENT_ID_BIT] = 1'b1;
						next_s.st1[ST1_NO_DATA_BIT] = 1'b1;
					end else begin
						next_s.st1[ST1_NO_DATA_BIT] = 1'b1;
					end
					next_s.state = ST_IDLE;
					next_s.done = 1'b1;
				end else if (DISK_ID_VALID) begin
					next_s.id_found = 1'b1;
					if (s.p.code == CMD_READ_TRACK) begin
						// Bad CRC does not stop the track read
						if (DISK_ID != s.cur) begin
							next_s.st1[ST1_NO_DATA_BIT] = 1'b1;
						end
						next_s.state = ST_WAIT_MARK;
					end else if (s.p.code == CMD_READ_ID) begin
						if (DISK_ID_CRC_OK) begin
							next_s.cur = DISK_ID;
							next_s.state = ST_IDLE;
							next_s.done = 1'b1;
						end
					end else if (DISK_ID_CRC_OK && DISK_ID.r == s.cur.r) begin
						next_s.idx_cnt = 2'h0;
						next_s.byte_cnt = 14'h0000;
						next_s.fph = FMT_DATA_MARK;
						next_s.svc_cnt = 13'h0000;
						next_s.state = is_write ? ST_WRITE_DATA : ST_WAIT_MARK;
					end
				end
			end
			ST_WAIT_MARK: begin
				if (DISK_MARK_VALID) begin
					next_s.byte_cnt = 14'h0000;
					next_s.state = ST_READ_DATA;
					if (s.p.code == CMD_READ_DELETED && !DISK_MARK_DELETED) begin
						if (s.p.skip_deleted) begin
							next_s.cur.r = s.cur.r + 8'h01;
							next_s.state = ST_SEEK_ID;
						end else begin
							next_s.cm_pending = 1'b1;
						end
					end
				end
			end
			ST_READ_DATA: begin
				if (DISK_RD_VALID) begin
					next_s.rd_valid = 1'b1;
					next_s.rd_data = DISK_RD_DATA;
					next_s.byte_cnt = s.byte_cnt + 14'h0001;
					if (s.byte_cnt == sector_last) begin
						next_s.state = ST_SEEK_ID;
						if (s.p.code == CMD_READ_TRACK) begin
							next_s.sec_cnt = s.sec_cnt + 8'h01;
							if (s.sec_cnt + 8'h01 == s.p.end_sector_number) begin
								next_s.state = ST_IDLE;
								next_s.done = 1'b1;
							end
						end else begin
							next_s.cur.r = s.cur.r + 8'h01;
							if (s.cm_pending || s.tc_seen || s.cur.r == s.p.end_sector_number) begin
								next_s.st2[ST2_CONTROL_MARK_BIT] = s.cm_pending;
								next_s.state = ST_IDLE;
								next_s.done = 1'b1;
							end
						end
					end
				end
			end
			ST_WRITE_DATA: begin
				if (HOST_WR_VALID && dreq) begin
					next_s.hold = HOST_WR_DATA;
					next_s.hold_full = 1'b1;
					next_s.svc_cnt = 13'h0000;
				end else if (dreq) begin
					next_s.svc_cnt = s.svc_cnt + 13'h0001;
				end
				if (dreq && s.svc_cnt == svc_limit) begin
					// Host missed its service window
					next_s.st1[ST1_OVERRUN_BIT] = 1'b1;
					next_s.st0[ST0_IC_HI:ST0_IC_LO] = 2'b01;
					next_s.state = ST_IDLE;
					next_s.done = 1'b1;
				end else if (slot_free && s.fph == FMT_DATA_MARK) begin
					next_s.wr.valid = 1'b1;
					next_s.wr.data = PAD_BYTE;
					next_s.wr.mark = (s.p.code == CMD_WRITE_DELETED) ? MARK_DELETED : MARK_DATA;
					next_s.fph = FMT_FILL;
				end else if (slot_free && (s.tc_seen || s.hold_full)) begin
					next_s.wr.valid = 1'b1;
					next_s.wr.mark = MARK_NONE;
					next_s.wr.data = s.hold_full ? s.hold : PAD_BYTE;
					next_s.hold_full = 1'b0;
					next_s.byte_cnt = s.byte_cnt + 14'h0001;
					if (s.byte_cnt == sector_last) begin
						next_s.cur.r = s.cur.r + 8'h01;
						next_s.state = ST_SEEK_ID;
						if (fault_lvl) begin
							next_s.st0[ST0_FAULT_BIT] = 1'b1;
							next_s.st0[ST0_IC_HI:ST0_IC_LO] = 2'b01;
							next_s.state = ST_IDLE;
							next_s.done = 1'b1;
						end else if (s.tc_seen || TERMINAL_COUNT
							|| s.cur.r == s.p.end_sector_number) begin
							next_s.state = ST_IDLE;
							next_s.done = 1'b1;
						end
					end
				end
			end
			ST_FORMAT: begin
				if (s.idx_cnt == INDEX_LIMIT) begin
					// Second index closes the track
					next_s.state = ST_IDLE;
					next_s.done = 1'b1;
					if (fault_lvl) begin
						next_s.st0[ST0_FAULT_BIT] = 1'b1;
						next_s.st0[ST0_IC_HI:ST0_IC_LO] = 2'b01;
					end
				end else if (s.fph == FMT_REQUEST) begin
					// Request drops for a cycle after each byte, so each ID byte is its own request
					next_s.hold_full = 1'b0;
					if (HOST_WR_VALID && dreq) begin
						case (s.byte_cnt[1:0])
							2'h0: next_s.fmt_id.c = HOST_WR_DATA;
							2'h1: next_s.fmt_id.h = HOST_WR_DATA;
							2'h2: next_s.fmt_id.r = HOST_WR_DATA;
							default: next_s.fmt_id.n = HOST_WR_DATA;
						endcase
						next_s.hold_full = 1'b1;
						next_s.byte_cnt = s.byte_cnt + 14'h0001;
						if (s.byte_cnt[1:0] == ID_BYTES_LAST) begin
							next_s.byte_cnt = 14'h0000;
							next_s.fph = FMT_GAP_A;
						end
					end
				end else if (slot_free) begin
					next_s.wr.valid = 1'b1;
					next_s.wr.mark = MARK_NONE;
					next_s.wr.data = GAP_FILL_BYTE;
					next_s.byte_cnt = s.byte_cnt + 14'h0001;
					case (s.fph)
						FMT_GAP_A, FMT_GAP_B: begin
							next_s.wr.mark = MARK_GAP;
							if (s.byte_cnt[7:0] + 8'h01 >= s.p.gap_length) begin
								next_s.byte_cnt = 14'h0000;
								next_s.fph = (s.fph == FMT_GAP_A) ? FMT_ID_MARK : FMT_DATA_MARK;
							end
						end
						FMT_ID_MARK: begin
							next_s.wr.mark = MARK_ID;
							next_s.byte_cnt = 14'h0000;
							next_s.fph = FMT_ID_BYTES;
						end
						FMT_ID_BYTES: begin
							case (s.byte_cnt[1:0])
								2'h0: next_s.wr.data = s.fmt_id.c;
								2'h1: next_s.wr.data = s.fmt_id.h;
								2'h2: next_s.wr.data = s.fmt_id.r;
								default: next_s.wr.data = s.fmt_id.n;
							endcase
							if (s.byte_cnt[1:0] == ID_BYTES_LAST) begin
								next_s.byte_cnt = 14'h0000;
								next_s.fph = FMT_GAP_B;
							end
						end
						FMT_DATA_MARK: begin
							next_s.wr.mark = MARK_DATA;
							next_s.byte_cnt = 14'h0000;
							next_s.fph = FMT_FILL;
						end
						FMT_FILL: begin
							next_s.wr.data = s.p.fill;
							if (s.byte_cnt == sector_last) begin
								next_s.byte_cnt = 14'h0000;
								next_s.cur = s.fmt_id;
								next_s.cur.r = s.fmt_id.r + 8'h01;
								next_s.sec_cnt = s.sec_cnt + 8'h01;
								next_s.fph = (s.sec_cnt + 8'h01 == s.p.sectors_per_track)
									? FMT_TAIL : FMT_REQUEST;
							end
						end
						default: begin
							// Track tail is gap bytes until the closing index
							next_s.wr.mark = MARK_GAP;
							next_s.byte_cnt = 14'h0000;
						end
					endcase
				end
			end
			default: begin
				next_s.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign BUSY = (s.state != ST_IDLE);
	assign DONE = s.done;
	assign RESULT = '{st0: s.st0, st1: s.st1, st2: s.st2, id: s.cur};
	assign HOST_DREQ = dreq;
	assign HOST_RD_VALID = s.rd_valid;
	assign HOST_RD_DATA = s.rd_data;
	assign HEAD_LOAD = BUSY;
	assign DISK_WR = s.wr;
endmodule // floppy_track_command_engine

// >>> logic/level_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs change slowly relative to the clock; no pulse stretching.
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	always_comb begin
		next_s.meta = d;
		next_s.sync = s.meta;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.sync;
endmodule // level_sync

// >>> pkg/fdc_track_pkg.sv
// Constants, enumerations and carrier types for the floppy track command engine.
// Assumes a single 250 MHz controller clock shared by the engine and its byte codec.
package fdc_track_pkg;

	localparam int CLK_MHZ = 250;
	localparam int WR_SERVICE_FM_US = 31;
	localparam int WR_SERVICE_MFM_US = 15;
	// Longest allowed times round down to whole cycles
	localparam int WR_SERVICE_FM_CYC = WR_SERVICE_FM_US * CLK_MHZ;
	localparam int WR_SERVICE_MFM_CYC = WR_SERVICE_MFM_US * CLK_MHZ;

	localparam int SECTOR_BASE_BYTES = 128;
	localparam logic [2:0] SIZE_CODE_MAX = 3'h6;
	localparam logic [7:0] GAP_FILL_BYTE = 8'h4E;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	localparam logic [1:0] ID_BYTES_LAST = 2'h3;
	localparam logic [1:0] INDEX_LIMIT = 2'h2;

	// Status bit positions
	localparam int ST0_IC_HI = 7;
	localparam int ST0_IC_LO = 6;
	localparam int ST0_FAULT_BIT = 4;
	localparam int ST0_NOT_READY_BIT = 3;
	localparam int ST1_ABSENT_ID_BIT = 0;
	localparam int ST1_NO_DATA_BIT = 2;
	localparam int ST1_OVERRUN_BIT = 4;
	localparam int ST2_CONTROL_MARK_BIT = 6;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] SETTLE_RESET = 16'h0000;

	typedef enum logic [2:0] {
		CMD_WRITE = 3'h0,
		CMD_WRITE_DELETED = 3'h1,
		CMD_READ_DELETED = 3'h2,
		CMD_READ_TRACK = 3'h3,
		CMD_READ_ID = 3'h4,
		CMD_FORMAT = 3'h5
	} cmd_t;

	typedef enum logic [2:0] {
		MARK_NONE = 3'h0,
		MARK_GAP = 3'h1,
		MARK_ID = 3'h2,
		MARK_DATA = 3'h3,
		MARK_DELETED = 3'h4
	} mark_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SETTLE = 4'h1,
		ST_WAIT_INDEX = 4'h2,
		ST_SEEK_ID = 4'h3,
		ST_WAIT_MARK = 4'h4,
		ST_READ_DATA = 4'h5,
		ST_WRITE_DATA = 4'h6,
		ST_FORMAT = 4'h7
	} state_t;

	typedef enum logic [2:0] {
		FMT_REQUEST = 3'h0,
		FMT_GAP_A = 3'h1,
		FMT_ID_MARK = 3'h2,
		FMT_ID_BYTES = 3'h3,
		FMT_GAP_B = 3'h4,
		FMT_DATA_MARK = 3'h5,
		FMT_FILL = 3'h6,
		FMT_TAIL = 3'h7
	} fmt_phase_t;

	typedef struct packed {
		logic [7:0] c;
		logic [7:0] h;
		logic [7:0] r;
		logic [7:0] n;
	} chrn_t;

	typedef struct packed {
		cmd_t code;
		logic mfm;
		logic skip_deleted;
		logic [2:0] size_code;
		logic [7:0] end_sector_number;
		logic [7:0] sectors_per_track;
		logic [7:0] gap_length;
		logic [7:0] fill;
		chrn_t id_compare_register;
	} cmd_params_t;

	typedef struct packed {
		logic valid;
		mark_t mark;
		logic [7:0] data;
	} disk_byte_t;

	typedef struct packed {
		logic [7:0] st0;
		logic [7:0] st1;
		logic [7:0] st2;
		chrn_t id;
	} result_t;

endpackage

// >>> sim/disk_model.sv
// Drive and byte codec model on the engine's disk side.
// Assumes the bench calls one task at a time; writes are logged in wq.
`timescale 1ns/1ps
module disk_model
	import fdc_track_pkg::*;
(
	// Clock
	input wire logic clk,
	// Drive pins
	output logic index,
	output logic fault,
	output logic ready,
	// Read side
	output logic id_valid,
	output chrn_t id,
	output logic crc_ok,
	output logic mark_valid,
	output logic mark_deleted,
	output logic rd_valid,
	output logic [7:0] rd_data,
	// Write side
	input wire disk_byte_t wr,
	output logic wr_ready
);
	disk_byte_t wq[$];
	logic [1:0] pace = 2'h0;
	initial begin
		index = 1'b0;
		fault = 1'b0;
		ready = 1'b1;
		id_valid = 1'b0;
		id = '0;
		crc_ok = 1'b0;
		mark_valid = 1'b0;
		mark_deleted = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
	end
	// Stall one cycle in four so held bytes are exercised
	always @(posedge clk) pace <= pace + 2'h1;
	assign wr_ready = pace != 2'h3;
	always @(posedge clk) if (wr.valid && wr_ready) wq.push_back(wr);
	task automatic set_drive(input logic f, input logic r);
		fault <= f;
		ready <= r;
	endtask
	task automatic pulse_index();
		@(posedge clk);
		index <= 1'b1;
		repeat (4) @(posedge clk);
		index <= 1'b0;
	endtask
	task automatic send_id(input chrn_t v, input logic good);
		@(posedge clk);
		id_valid <= 1'b1;
		id <= v;
		crc_ok <= good;
		@(posedge clk);
		id_valid <= 1'b0;
		id <= ~v;
		crc_ok <= ~good;
	endtask
	task automatic send_sector(input chrn_t v, input logic good, input logic del, input int n);
		send_id(v, good);
		repeat (4) @(posedge clk);
		mark_valid <= 1'b1;
		mark_deleted <= del;
		@(posedge clk);
		mark_valid <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rd_valid <= 1'b1;
			rd_data <= 8'(i);
			@(posedge clk);
			rd_valid <= 1'b0;
			rd_data <= ~8'(i);
		end
	endtask
endmodule // disk_model

// >>> sim/tb.sv
// Self-checking bench for the track command engine.
// Assumes the disk model and the bound port checker.
`timescale 1ns/1ps
module tb;
	import fdc_track_pkg::*;
	logic clk, rstn, start, busy, done, dreq, wv, rdv, tc, hl;
	logic [7:0] wd, rdd;
	cmd_params_t prm, p;
	result_t result, res;
	disk_byte_t dwr;
	chrn_t g;
	logic [7:0] exp [10];
	logic [31:0] seed = 32'h00012B7D;
	int error_cnt = 0, checked = 0, rd_cnt = 0, n_id, n_fill;
	logic d_idx, d_flt, d_rdy, d_idv, d_crc, d_mkv, d_mkd, d_rdv, d_wrr;
	logic [7:0] d_rdd;
	chrn_t d_id;
	disk_model dm (.clk(clk), .index(d_idx), .fault(d_flt), .ready(d_rdy), .id_valid(d_idv),
		.id(d_id), .crc_ok(d_crc), .mark_valid(d_mkv), .mark_deleted(d_mkd), .rd_valid(d_rdv),
		.rd_data(d_rdd), .wr(dwr), .wr_ready(d_wrr));
	floppy_track_command_engine #(.WR_SERVICE_FM_LIMIT(40), .WR_SERVICE_MFM_LIMIT(40)) dut (
		.REF_CLK(clk), .RESETN(rstn), .CMD_START(start), .CMD_PARAMS(prm),
		.SETTLE_CYCLES(16'h0004), .BUSY(busy), .DONE(done), .RESULT(result),
		.HOST_DREQ(dreq), .HOST_WR_VALID(wv), .HOST_WR_DATA(wd), .HOST_RD_VALID(rdv),
		.HOST_RD_DATA(rdd), .TERMINAL_COUNT(tc), .DRIVE_INDEX(d_idx),
		.DRIVE_FAULT(d_flt), .DRIVE_READY(d_rdy), .HEAD_LOAD(hl),
		.DISK_ID_VALID(d_idv), .DISK_ID(d_id), .DISK_ID_CRC_OK(d_crc),
		.DISK_MARK_VALID(d_mkv), .DISK_MARK_DELETED(d_mkd),
		.DISK_RD_VALID(d_rdv), .DISK_RD_DATA(d_rdd), .DISK_WR(dwr),
		.DISK_WR_READY(d_wrr));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// The model sends byte i of a sector as value i
	always @(posedge clk) begin
		if (rdv === 1'b1) begin
			chk(rdd, 8'(rd_cnt));
			rd_cnt++;
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic cmd_params_t mk(input cmd_t c, input logic [7:0] e);
		cmd_params_t q;
		q = '0;
		q.code = c;
		q.end_sector_number = e;
		q.id_compare_register = chrn_t'(rnd());
		return q;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic go(input cmd_params_t q, input int w);
		@(posedge clk);
		start <= 1'b1;
		prm <= q;
		@(posedge clk);
		start <= 1'b0;
		repeat (w) @(posedge clk);
	endtask
	// Bounded wait on a design output sampled mid-cycle
	task automatic wait_for(input bit want_done);
		int n;
		n = 0;
		@(negedge clk);
		while ((want_done ? done : dreq) !== 1'b1 && n < 5000) begin
			n++;
			@(negedge clk);
		end
		if (n >= 5000) chk(0, 1);
		res = result;
	endtask
	task automatic feed(input logic [7:0] b);
		wait_for(0);
		@(posedge clk);
		wv <= 1'b1;
		wd <= b;
		@(posedge clk);
		wv <= 1'b0;
	endtask
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		prm = '0;
		wv = 1'b0;
		wd = 8'h00;
		tc = 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		dm.set_drive(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		go(mk(CMD_WRITE, 8'hFF), 0);
		wait_for(1);
		chk(res.st0, 8'h48);
		chk(busy, 1'b0);
		dm.set_drive(1'b0, 1'b1);
		repeat (4) @(posedge clk);
		p = mk(CMD_WRITE, 8'hFF);
		p.mfm = 1'b1;
		go(p, 10);
		dm.send_id(p.id_compare_register, 1'b1);
		wait_for(1);
		chk(res.st1[ST1_OVERRUN_BIT], 1'b1);
		chk(res.st0[7:6], 2'h1);
		p = mk(CMD_WRITE_DELETED, 8'hFF);
		dm.wq.delete();
		go(p, 10);
		dm.send_id(p.id_compare_register, 1'b1);
		for (int i = 0; i < 10; i++) begin
			exp[i] = 8'(rnd());
			feed(exp[i]);
		end
		@(posedge clk);
		tc <= 1'b1;
		dm.set_drive(1'b1, 1'b1);
		@(posedge clk);
		tc <= 1'b0;
		wait_for(1);
		// Last data byte is still in the codec slot when the command ends
		repeat (4) @(posedge clk);
		chk(dm.wq.size(), 129);
		chk(dm.wq[0].mark, MARK_DELETED);
		for (int i = 1; i < 129; i++) begin
			chk(dm.wq[i], {1'b1, MARK_NONE, i <= 10 ? exp[i - 1] : PAD_BYTE});
		end
		chk({res.st0[7:6], res.st0[ST0_FAULT_BIT]}, 3'h3);
		dm.set_drive(1'b0, 1'b1);
		// Next command neither steps nor changes side
		repeat (4) @(posedge clk);
		p = mk(CMD_FORMAT, 8'h00);
		p.sectors_per_track = 8'h02;
		p.gap_length = 8'h03;
		p.fill = {1'b1, 7'(rnd())};
		dm.wq.delete();
		go(p, 10);
		dm.pulse_index();
		for (int s = 0; s < 2; s++) begin
			feed(8'h05);
			feed(8'h01);
			feed(8'(s + 3));
			feed(8'h00);
		end
		repeat (800) @(posedge clk);
		dm.pulse_index();
		wait_for(1);
		n_id = 0;
		n_fill = 0;
		foreach (dm.wq[i]) begin
			if (dm.wq[i].mark == MARK_ID) n_id++;
			if (dm.wq[i].mark == MARK_NONE && dm.wq[i].data == p.fill) n_fill++;
		end
		chk(n_id, 2);
		chk(n_fill, 256);
		chk(res.id.r, 8'h05);
		p = mk(CMD_READ_ID, 8'h00);
		g = chrn_t'(rnd());
		go(p, 10);
		dm.send_id(~g, 1'b0);
		dm.send_id(g, 1'b1);
		wait_for(1);
		chk(res.id, g);
		go(p, 10);
		dm.pulse_index();
		repeat (20) @(posedge clk);
		dm.pulse_index();
		wait_for(1);
		chk({res.st1[ST1_NO_DATA_BIT], res.st1[ST1_ABSENT_ID_BIT]}, 2'h3);
		chk(res.st0[7:6], 2'h1);
		// Skip bypass stays clear for the track read
		p = mk(CMD_READ_TRACK, 8'h01);
		go(p, 10);
		rd_cnt = 0;
		dm.pulse_index();
		dm.send_sector(~p.id_compare_register, 1'b0, 1'b0, 128);
		wait_for(1);
		@(negedge clk);
		chk(rd_cnt, 128);
		chk(res.st1[ST1_NO_DATA_BIT], 1'b1);
		go(mk(CMD_READ_TRACK, 8'h01), 10);
		dm.pulse_index();
		repeat (20) @(posedge clk);
		dm.pulse_index();
		wait_for(1);
		chk({res.st0[7:6], res.st1[ST1_ABSENT_ID_BIT]}, 3'h3);
		p = mk(CMD_READ_DELETED, 8'hFF);
		go(p, 10);
		rd_cnt = 0;
		dm.send_sector(p.id_compare_register, 1'b1, 1'b0, 128);
		wait_for(1);
		@(negedge clk);
		chk(rd_cnt, 128);
		chk(res.st2[ST2_CONTROL_MARK_BIT], 1'b1);
		p = mk(CMD_READ_DELETED, 8'h00);
		p.skip_deleted = 1'b1;
		g = p.id_compare_register;
		p.end_sector_number = g.r + 8'h01;
		go(p, 10);
		rd_cnt = 0;
		dm.send_sector(g, 1'b1, 1'b0, 0);
		g.r = g.r + 8'h01;
		dm.send_sector(g, 1'b1, 1'b1, 128);
		wait_for(1);
		@(negedge clk);
		chk(rd_cnt, 128);
		chk(res.id.r, 8'(g.r + 8'h01));
		chk(res.st2[ST2_CONTROL_MARK_BIT], 1'b0);
		end_sim();
	end
endmodule // tb

// >>> sim/track_engine_props.sv
// Port checker for the track command engine.
// Assumes one clock domain; bound to every engine instance.
`timescale 1ns/1ps
module track_engine_props
	import fdc_track_pkg::*;
#(
	parameter int WR_SERVICE_FM_LIMIT = WR_SERVICE_FM_CYC,
	parameter int WR_SERVICE_MFM_LIMIT = WR_SERVICE_MFM_CYC
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// Command and host
	input wire logic CMD_START,
	input wire logic BUSY,
	input wire logic DONE,
	input wire result_t RESULT,
	input wire logic HOST_DREQ,
	input wire logic HOST_WR_VALID,
	input wire logic HOST_RD_VALID,
	input wire logic HEAD_LOAD,
	// Codec
	input wire logic DISK_RD_VALID,
	input wire disk_byte_t DISK_WR,
	input wire logic DISK_WR_READY
);
	// Slack covers the registered end of the command
	localparam int LIM = (WR_SERVICE_FM_LIMIT > WR_SERVICE_MFM_LIMIT ?
		WR_SERVICE_FM_LIMIT : WR_SERVICE_MFM_LIMIT) + 3;
	int wait_cnt;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	always_ff @(posedge REF_CLK) begin
		if (!RESETN || !HOST_DREQ || HOST_WR_VALID) begin
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	a_start_answered: assert property (CMD_START && !BUSY |=> BUSY || DONE)
		else $error("start not answered");
	a_busy_cause: assert property ($rose(BUSY) |-> $past(CMD_START))
		else $error("busy without start");
	a_head_loaded: assert property (BUSY |-> HEAD_LOAD)
		else $error("head not loaded");
	a_done_ends: assert property (DONE |=> !DONE && !BUSY)
		else $error("done not a pulse");
	a_idle_quiet: assert property (!BUSY |-> !HOST_DREQ)
		else $error("request while idle");
	a_host_taken: assert property (HOST_DREQ && HOST_WR_VALID |=> !HOST_DREQ)
		else $error("request stays after byte");
	a_disk_hold: assert property (DISK_WR.valid && !DISK_WR_READY |=> $stable(DISK_WR))
		else $error("disk byte changed");
	a_read_follow: assert property (HOST_RD_VALID |-> $past(DISK_RD_VALID))
		else $error("read byte without cause");
	a_service_bound: assert property (wait_cnt <= LIM)
		else $error("service wait too long");
	a_fault_code: assert property (DONE && RESULT.st0[ST0_FAULT_BIT] |-> RESULT.st0[7:6] == 2'h1)
		else $error("fault code wrong");
	a_overrun_code: assert property (DONE && RESULT.st1[ST1_OVERRUN_BIT] |-> RESULT.st0[7:6] == 2'h1)
		else $error("overrun code wrong");
	c_overrun: cover property (DONE && RESULT.st1[ST1_OVERRUN_BIT]);
	c_refused: cover property (CMD_START && !BUSY ##1 DONE && !BUSY);
	c_read_byte: cover property (HOST_RD_VALID);
endmodule // track_engine_props

bind floppy_track_command_engine track_engine_props #(
	.WR_SERVICE_FM_LIMIT(WR_SERVICE_FM_LIMIT),
	.WR_SERVICE_MFM_LIMIT(WR_SERVICE_MFM_LIMIT)
) props (
	.REF_CLK, .RESETN, .CMD_START, .BUSY, .DONE, .RESULT, .HOST_DREQ,
	.HOST_WR_VALID, .HOST_RD_VALID, .HEAD_LOAD, .DISK_RD_VALID, .DISK_WR, .DISK_WR_READY
);
